// ==== common/phy_regs_pkg.sv ====
// Constants and types of the transceiver control and status registers.
// Assumes a 100 MHz system clock and 32-bit APB register words.
package phy_regs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // Byte addresses of the two registers.
  localparam logic [7:0] CTRL_OFFSET   = 8'hB4;
  localparam logic [7:0] STATUS_OFFSET = 8'hB8;

  // Control bit positions.
  localparam int unsigned RST_BIT    = 15;
  localparam int unsigned LOOP_BIT   = 14;
  localparam int unsigned SPEED_BIT  = 13;
  localparam int unsigned AUTONEG_ENABLE_BIT   = 12;
  localparam int unsigned PDOWN_BIT  = 11;
  localparam int unsigned ANRS_BIT   = 9;
  localparam int unsigned DUPLEX_BIT = 8;
  localparam int unsigned COLT_BIT   = 7;

  localparam logic [15:0] CTRL_WRITABLE = 16'hFB80;
  localparam logic [15:0] CTRL_SELF_CLR = 16'h8200;
  localparam logic [15:0] CTRL_RESET    = 16'h3000;
  localparam logic [15:0] STATUS_FIXED  = 16'h7809;
  localparam logic [3:0]  STRB_FULL     = 4'hF;

  // Duration of a transceiver reset and of a negotiation restart.
  localparam int unsigned PHY_RESET_NS  = 1000;
  localparam int unsigned AN_RESTART_NS = 20;
  localparam int unsigned CNT_W         = 8;
  localparam logic [CNT_W-1:0] PHY_RESET_CYC =
    CNT_W'((PHY_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] AN_RESTART_CYC =
    CNT_W'((AN_RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic resetActive;
    logic loopback;
    logic powerDown;
    logic collisionTest;
    logic autonegEnable;
    logic autonegRestart;
    logic speed100;
    logic fullDuplex;
  } phy_ctrl_s;

  localparam phy_ctrl_s PHY_CTRL_RESET = '{
    resetActive: 1'b0, loopback: 1'b0, powerDown: 1'b0,
    collisionTest: 1'b0, autonegEnable: 1'b1, autonegRestart: 1'b0,
    speed100: 1'b1, fullDuplex: 1'b0};

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             busy;
    logic             done;
  } timer_s;

endpackage

// ==== verilog/phy_pulse_timer.sv ====
// Counts a fixed number of cycles after a start and then pulses done.
// Assumes CYCLES is at least one; a new start reloads the count.
module phy_pulse_timer
  import phy_regs_pkg::*;
#(
  parameter logic [CNT_W-1:0] CYCLES = 8'h01
)
(
  input  wire logic sys_clk, // System clock.
  input  wire logic rstn,    // Asynchronous reset, active low.
  input  wire logic start,   // Starts or restarts the interval.
  output logic      busy,    // High while the interval runs.
  output logic      done     // One-cycle pulse at the end.
);

  timer_s stateReg;
  timer_s stateNext;

  always_comb
  begin
    stateNext      = stateReg;
    stateNext.done = 1'b0;
    if (start)
    begin
      stateNext.count = CYCLES;
      stateNext.busy  = 1'b1;
    end
    else if (stateReg.busy)
    begin
      if (stateReg.count == CNT_W'(1))
      begin
        stateNext.busy  = 1'b0;
        stateNext.done  = 1'b1;
        stateNext.count = '0;
      end
      else
      begin
        stateNext.count = stateReg.count - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      stateReg <= '0;
    else
      stateReg <= stateNext;
  end

  assign busy = stateReg.busy;
  assign done = stateReg.done;

endmodule // phy_pulse_timer

// ==== verilog/phy_control_status_regs.sv ====
// Transceiver control and basic status registers behind an APB slave.
// Assumes APB4 signalling on sys_clk; negotiation results come in
// synchronous to sys_clk.
//
// Overview of operation
// - Eleven 16-bit transceiver registers; control and status live here.
// - Only full 32-bit word accesses; upper half of each word is ignored.
// - Writing one to control bit 15 resets transceiver; bit self-clears.
// - Control bit 14 selects loopback; software keeps MAC mode field at 00.
// - Control bit 13 forces 100 or 10 Mbps unless negotiation enabled.
// - Control bit 12 enables auto-negotiation.
// - Control bit 11 powers the transceiver down; default zero.
// - Writing one to control bit 9 restarts negotiation; bit self-clears.
// - Control bit 8 forces full duplex unless negotiation enabled.
// - Control bit 7 enables the collision test; default zero.
// - The status register is read-only; writes have no effect.
// - Status bit 15, four-pair ability, always reads zero.
// - Status bits 14 and 13 always read one.
module phy_control_status_regs
  import phy_regs_pkg::*;
(
  input  wire logic        sys_clk,        // System clock, 100 MHz.
  input  wire logic        rstn,           // Async reset, active low.
  input  wire logic        psel,           // APB select.
  input  wire logic        penable,        // APB access phase.
  input  wire logic        pwrite,         // APB write when high.
  input  wire logic [7:0]  paddr,          // APB byte address.
  input  wire logic [31:0] pwdata,         // APB write data.
  input  wire logic [3:0]  pstrb,          // APB byte strobes.
  output logic      [31:0] prdata,         // APB read data.
  output logic             pready,         // APB ready.
  output logic             pslverr,        // APB error answer.
  input  wire logic        anResolved100,  // Negotiated 100 Mbps.
  input  wire logic        anResolvedFull, // Negotiated full duplex.
  output phy_ctrl_s        phyCtrl         // Transceiver controls.
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [31:0] rdata;
    logic        ready;
    logic        slvErr;
    phy_ctrl_s   phy;
  } state_s;

  localparam state_s STATE_RESET = '{
    ctrl: CTRL_RESET, rdata: '0, ready: 1'b0, slvErr: 1'b0,
    phy: PHY_CTRL_RESET};

  localparam int RST_BOUND = PHY_RESET_CYC + 2;
  localparam int AN_BOUND  = AN_RESTART_CYC + 2;

  state_s      stateReg;
  state_s      stateNext;
  logic        setupPhase;
  logic        commit;
  logic        fullWord;
  logic        ctrlWrite;
  logic        statusWrite;
  logic [15:0] ctrlNext;
  logic        rstStart;
  logic        rstBusy;
  logic        rstDone;
  logic        anStart;
  logic        anBusy;
  logic        anDone;

  function automatic logic isCtrl(input logic [7:0] addr);
    return addr == CTRL_OFFSET;
  endfunction

  function automatic logic isStatus(input logic [7:0] addr);
    return addr == STATUS_OFFSET;
  endfunction

  // The other nine transceiver registers live elsewhere.
  function automatic logic [31:0] readWord(input logic [7:0]  addr,
                                           input logic [15:0] ctrl);
    logic [31:0] word;
    word = '0;
    if (isCtrl(addr))
      word = {16'h0000, ctrl & CTRL_WRITABLE};
    else if (isStatus(addr))
      word = {16'h0000, STATUS_FIXED};
    return word;
  endfunction

  always_comb
  begin
    setupPhase  = psel && !penable;
    commit      = psel && penable && stateReg.ready;
    fullWord    = pstrb == STRB_FULL;
    ctrlWrite   = commit && pwrite && fullWord && isCtrl(paddr);
    statusWrite = commit && pwrite && isStatus(paddr);
    rstStart    = ctrlWrite && pwdata[RST_BIT];
    anStart     = ctrlWrite && pwdata[ANRS_BIT];
  end

  always_comb
  begin
    stateNext = stateReg;
    ctrlNext  = stateReg.ctrl;
    // Self-clearing bits drop when their interval ends.
    if (rstDone)
      ctrlNext[RST_BIT] = 1'b0;
    if (anDone)
      ctrlNext[ANRS_BIT] = 1'b0;
    // A write sets self-clearing bits but never clears them, and a new
    // set in the cycle of the clear wins.
    if (ctrlWrite)
    begin
      ctrlNext = (pwdata[15:0] & CTRL_WRITABLE & ~CTRL_SELF_CLR)
               | (ctrlNext & CTRL_SELF_CLR)
               | (pwdata[15:0] & CTRL_SELF_CLR);
    end
    // Writes to the status word change nothing.
    stateNext.ctrl = ctrlNext;

    // Every transfer completes in its first access cycle.
    stateNext.ready  = setupPhase;
    stateNext.slvErr = setupPhase
                     && (!(isCtrl(paddr) || isStatus(paddr))
                         || (pwrite && !fullWord));
    stateNext.rdata  = (setupPhase && !pwrite)
                     ? readWord(paddr, stateReg.ctrl) : '0;

    stateNext.phy.resetActive    = ctrlNext[RST_BIT];
    stateNext.phy.loopback       = ctrlNext[LOOP_BIT];
    stateNext.phy.powerDown      = ctrlNext[PDOWN_BIT];
    stateNext.phy.collisionTest  = ctrlNext[COLT_BIT];
    stateNext.phy.autonegEnable  = ctrlNext[AUTONEG_ENABLE_BIT];
    stateNext.phy.autonegRestart = anDone;
    // Forced speed and duplex give way to negotiation.
    stateNext.phy.speed100   = ctrlNext[AUTONEG_ENABLE_BIT]
                             ? anResolved100 : ctrlNext[SPEED_BIT];
    stateNext.phy.fullDuplex = ctrlNext[AUTONEG_ENABLE_BIT]
                             ? anResolvedFull : ctrlNext[DUPLEX_BIT];
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      stateReg <= STATE_RESET;
    else
      stateReg <= stateNext;
  end

  assign prdata  = stateReg.rdata;
  assign pready  = stateReg.ready;
  assign pslverr = stateReg.slvErr;
  assign phyCtrl = stateReg.phy;

  phy_pulse_timer #(
    .CYCLES (PHY_RESET_CYC)
  ) resetTimer (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .start   (rstStart),
    .busy    (rstBusy),
    .done    (rstDone)
  );

  phy_pulse_timer #(
    .CYCLES (AN_RESTART_CYC)
  ) restartTimer (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .start   (anStart),
    .busy    (anBusy),
    .done    (anDone)
  );

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  partialWrite_a: assert property (
    setupPhase && pwrite && !fullWord
    |=> pslverr && pready ##1 !pready)
    else $error("Partial write not refused.");

  resetSelfClear_a: assert property (
    rstStart |=> phyCtrl.resetActive && stateReg.ctrl[RST_BIT]
    ##[1:RST_BOUND] !stateReg.ctrl[RST_BIT])
    else $error("Transceiver reset bit did not self-clear.");

  loopbackFollows_a: assert property (
    ctrlWrite |=> phyCtrl.loopback == $past(pwdata[LOOP_BIT]))
    else $error("Loopback did not follow the write.");

  property forcedMode(logic outBit, logic resolved, logic forced);
    $past(rstn) |-> outBit == (stateReg.ctrl[AUTONEG_ENABLE_BIT]
                               ? $past(resolved) : forced);
  endproperty

  forcedSpeed_a: assert property (
    forcedMode(phyCtrl.speed100, anResolved100,
               stateReg.ctrl[SPEED_BIT]))
    else $error("Speed output does not match its source.");

  anEnable_a: assert property (
    ctrlWrite && !pwdata[AUTONEG_ENABLE_BIT] |=> !phyCtrl.autonegEnable
    && (phyCtrl.speed100 == stateReg.ctrl[SPEED_BIT]))
    else $error("Negotiation not disabled by the write.");

  powerDown_a: assert property (
    ctrlWrite |=> phyCtrl.powerDown == $past(pwdata[PDOWN_BIT]))
    else $error("Power-down did not follow the write.");

  restartPulse_a: assert property (
    anStart |=> stateReg.ctrl[ANRS_BIT]
    ##[1:AN_BOUND] (phyCtrl.autonegRestart && !stateReg.ctrl[ANRS_BIT]))
    else $error("Negotiation restart did not complete.");

  forcedDuplex_a: assert property (
    forcedMode(phyCtrl.fullDuplex, anResolvedFull,
               stateReg.ctrl[DUPLEX_BIT]))
    else $error("Duplex output does not match its source.");

  collisionTest_a: assert property (
    ctrlWrite |=> phyCtrl.collisionTest == $past(pwdata[COLT_BIT]))
    else $error("Collision test did not follow the write.");

  statusWrite_a: assert property (
    statusWrite && !rstBusy && !anBusy && !rstDone && !anDone
    |=> $stable(stateReg.ctrl))
    else $error("Status write changed the control word.");

  statusRead_a: assert property (
    setupPhase && !pwrite && isStatus(paddr)
    |=> prdata[15:13] == 3'b011 && prdata[31:16] == 16'h0000)
    else $error("Status ability bits read wrong.");

  reservedZero_a: assert property (
    (stateReg.ctrl & ~CTRL_WRITABLE) == 16'h0000)
    else $error("Reserved control bits are not zero.");

  // Every setup cycle is answered in the next cycle, for one cycle only.
  readyPulse_a: assert property (
    setupPhase |=> pready ##1 !pready)
    else $error("Ready is not a one-cycle answer.");

  unmappedError_a: assert property (
    setupPhase && !(isCtrl(paddr) || isStatus(paddr))
    |=> pslverr && prdata == 32'h00000000)
    else $error("Unmapped address not refused.");

  // A refused partial write leaves the control word alone.
  partialIgnored_a: assert property (
    commit && pwrite && !fullWord && !rstDone && !anDone
    |=> $stable(stateReg.ctrl))
    else $error("Partial write changed the control word.");

  ctrlRead_a: assert property (
    setupPhase && !pwrite && isCtrl(paddr)
    |=> prdata == {16'h0000, $past(stateReg.ctrl)})
    else $error("Control read does not return the control word.");

  // Upper half and reserved bits of a write never reach the control word.
  upperIgnored_a: assert property (
    ctrlWrite |=> (stateReg.ctrl & ~CTRL_SELF_CLR)
                  == ($past(pwdata[15:0]) & CTRL_WRITABLE & ~CTRL_SELF_CLR))
    else $error("Write did not load the plain control bits.");

  // The reset bit cannot be cut short while its interval runs.
  resetHeld_a: assert property (
    rstBusy |-> stateReg.ctrl[RST_BIT] && phyCtrl.resetActive)
    else $error("Transceiver reset bit dropped early.");

  restartHeld_a: assert property (
    anBusy |-> stateReg.ctrl[ANRS_BIT])
    else $error("Restart bit dropped before the restart.");

  // With negotiation on, the forced bits must not leak to the outputs.
  anOverride_a: assert property (
    stateReg.ctrl[AUTONEG_ENABLE_BIT] && $past(rstn)
    |-> phyCtrl.speed100 == $past(anResolved100)
        && phyCtrl.fullDuplex == $past(anResolvedFull))
    else $error("Forced mode leaked while negotiating.");

  autonegFollows_a: assert property (
    ctrlWrite |=> phyCtrl.autonegEnable == $past(pwdata[AUTONEG_ENABLE_BIT]))
    else $error("Negotiation enable did not follow the write.");

  // Loopback, power-down and collision test hold between writes.
  levelsHold_a: assert property (
    !ctrlWrite |=> $stable(phyCtrl.loopback) && $stable(phyCtrl.powerDown)
                   && $stable(phyCtrl.collisionTest))
    else $error("A control level changed without a write.");

  // Status reads keep the upper half and the fault bits at zero.
  statusWord_a: assert property (
    setupPhase && !pwrite && isStatus(paddr)
    |=> prdata == {16'h0000, STATUS_FIXED})
    else $error("Status word read wrong.");

  // Only the access edge commits; a setup cycle never writes.
  setupNoWrite_a: assert property (
    setupPhase && !rstDone && !anDone |=> $stable(stateReg.ctrl))
    else $error("Control word changed in a setup cycle.");

  resetWrite_c: cover property (rstStart ##[1:RST_BOUND] rstDone);
  restart_c: cover property (anStart ##[1:AN_BOUND] anDone);
  statusRead_c: cover property (commit && !pwrite && isStatus(paddr));
  errorAnswer_c: cover property (pready && pslverr);
  forcedMode_c: cover property (!phyCtrl.autonegEnable && phyCtrl.speed100);

endmodule // phy_control_status_regs

// ==== verif/phy_control_status_regs_tb.sv ====
// Self-checking bench for the transceiver control and status registers.
// Assumes the zero-wait APB slave and register layout of phy_regs_pkg.
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  badCount++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module phy_control_status_regs_tb
  import phy_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        anResolved100 = 1'b0;
  logic        anResolvedFull = 1'b1;
  phy_ctrl_s   phyCtrl;
  int          badCount = 0;
  int          comparisons = 0;
  int          cycles = 0;

  phy_control_status_regs DUT (
    .sys_clk        (sys_clk),
    .rstn           (rstn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .pstrb          (pstrb),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .anResolved100  (anResolved100),
    .anResolvedFull (anResolvedFull),
    .phyCtrl        (phyCtrl)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic results();
    if (badCount == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A hang is cut off well beyond the fewer than two hundred cycles the tests need.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      badCount++;
      results();
    end
  end

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      input logic [31:0] expRd, input logic expErr);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    `CHK("pready", 1'b1, pready)
    `CHK("pslverr", expErr, pslverr)
    if (!w)
      `CHK("prdata", expRd, prdata)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic checkCtrl(input logic [7:0] expOut);
    repeat (3) @(negedge sys_clk);
    `CHK("phyCtrl", expOut, phyCtrl)
  endtask

  task automatic resetValues();
    `CHK("phyCtrlRst", 8'h0A, phyCtrl)
    xfer(1'b0, CTRL_OFFSET, 32'h0, 4'hF, 32'h00003000, 1'b0);
    xfer(1'b0, STATUS_OFFSET, 32'h0, 4'hF, 32'h7809, 1'b0);
  endtask

  task automatic statusReadOnly();
    xfer(1'b1, STATUS_OFFSET, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b0);
    xfer(1'b0, STATUS_OFFSET, 32'h0, 4'hF, 32'h00007809, 1'b0);
    xfer(1'b0, CTRL_OFFSET, 32'h0, 4'hF, 32'h00003000, 1'b0);
  endtask

  task automatic reservedAndUpper();
    xfer(1'b1, CTRL_OFFSET, 32'hFFFF5DFF, 4'hF, 32'h0, 1'b0);
    xfer(1'b0, CTRL_OFFSET, 32'h0, 4'hF, 32'h00005980, 1'b0);
    // Negotiation on: speed and duplex follow the resolved inputs.
    checkCtrl(8'h79);
  endtask

  task automatic forcedModes();
    // Negotiated results differ from both forced bits of the first write, which are ignored only while negotiation is on.
    @(posedge sys_clk);
    anResolved100  <= 1'b1;
    anResolvedFull <= 1'b0;
    xfer(1'b1, CTRL_OFFSET, 32'h00001100, 4'hF, 32'h0, 1'b0);
    checkCtrl(8'h0A);
    xfer(1'b1, CTRL_OFFSET, 32'h00002100, 4'hF, 32'h0, 1'b0);
    checkCtrl(8'h03);
    xfer(1'b1, CTRL_OFFSET, 32'h00000000, 4'hF, 32'h0, 1'b0);
    checkCtrl(8'h00);
  endtask

  task automatic restartNeg();
    int n;
    logic seen;
    seen = 1'b0;
    xfer(1'b1, CTRL_OFFSET, 32'h00001200, 4'hF, 32'h0, 1'b0);
    for (n = 0; n < 10; n++)
    begin
      @(negedge sys_clk);
      if (phyCtrl.autonegRestart === 1'b1)
        seen = 1'b1;
    end
    `CHK("restartPulse", 1'b1, seen)
    xfer(1'b0, CTRL_OFFSET, 32'h0, 4'hF, 32'h00001000, 1'b0);
  endtask

  task automatic softReset();
    int n;
    n = 0;
    xfer(1'b1, CTRL_OFFSET, 32'h00009000, 4'hF, 32'h0, 1'b0);
    xfer(1'b0, CTRL_OFFSET, 32'h0, 4'hF, 32'h00009000, 1'b0);
    `CHK("resetActive", 1'b1, phyCtrl.resetActive)
    // Writing zero while the reset runs must not cut it short.
    xfer(1'b1, CTRL_OFFSET, 32'h00001000, 4'hF, 32'h0, 1'b0);
    `CHK("resetHeld", 1'b1, phyCtrl.resetActive)
    while (phyCtrl.resetActive !== 1'b0 && n < 300)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("resetEnds", 1'b1, n < 300)
    xfer(1'b0, CTRL_OFFSET, 32'h0, 4'hF, 32'h00001000, 1'b0);
  endtask

  task automatic refusals();
    xfer(1'b0, 8'hBC, 32'h0, 4'hF, 32'h00000000, 1'b1);
    xfer(1'b1, 8'hBC, 32'h00004000, 4'hF, 32'h0, 1'b1);
    xfer(1'b1, CTRL_OFFSET, 32'h00004880, 4'h3, 32'h0, 1'b1);
    xfer(1'b0, CTRL_OFFSET, 32'h0, 4'hF, 32'h00001000, 1'b0);
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    resetValues();
    statusReadOnly();
    reservedAndUpper();
    forcedModes();
    restartNeg();
    softReset();
    refusals();
    results();
  end
endmodule // phy_control_status_regs_tb
